// *** src/pesc_regs.sv ***
// Notes on behaviour
// (RULE_01) Flags record any event since last read
// (RULE_02) Flags capture even when interrupt masked
// (RULE_03) Bits 15..10 latch high, clear on read
// (RULE_04) Bits 8..4 and 0 latch, clear on read
// (RULE_05) Bit 9 shows EEE error, not read-cleared
// (RULE_06) Bit 3 shows wake packet received
// (RULE_07) Bit 2 shows MAC buffer fault
// (RULE_08) Bit 1 latches polarity change until read
// (RULE_09) Write one starts probe; hardware clears it
// (RULE_10) Bit 13 sets interrupt polarity, reset one
// (RULE_11) Bits 11-10 pick retries 1,2,4,8
// (RULE_12) Bit 9 enables downshift, reset zero
// (RULE_13) Bit 8 enables enhanced C/D downshift
// (RULE_14) Bit 6 enables fallback to 10M
// (RULE_15) Bits 5-4 select gigabit transmit clock
// (RULE_16) Bit 3 enables full duplex collision
// (RULE_17) Bit 2 enables legacy scrambler selection
// (RULE_18) Bits 1,0 enable semi-cross master/slave
// (RULE_19) 16-bit error counter, write ones clears
// (RULE_20) Enabled pending event asserts interrupt pin
// (RULE_21) Event during read survives the read
`timescale 1ns/1ps
`include "pesc_consts.svh"

module pesc_regs
  import pesc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Event pulses, one per flag position; bits 9, 3, 2 unused here
  input wire logic [15:0] event_pulse,
  // Level indications shown directly in the flag register
  input wire logic eee_error_level,
  input wire logic wake_packet_level,
  input wire logic mac_buffer_fault_level,
  // Interrupt enables held in the mask register outside
  input wire logic [15:0] event_enable_mask,
  // Hardware completion of the powered-device probe
  input wire logic probe_done,
  // One receive error seen
  input wire logic rx_error,
  // Interrupt pin, configuration and error counter outputs
  output logic event_irq_pin,
  output logic powered_device_probe_start,
  output logic [1:0] downshift_retry_count,
  output logic [3:0] downshift_retry_limit,
  output logic downshift_enable,
  output logic downshift_enhanced_enable,
  output logic downshift_to_ten_enable,
  output logic [1:0] tx_clk_select,
  output logic tx_clk_running,
  output logic full_duplex_collision_enable,
  output logic legacy_scrambler_auto_enable,
  output logic semi_cross_master_enable,
  output logic semi_cross_slave_enable,
  output logic [15:0] rx_error_tally
);

  // ****************************************
  // State
  // ****************************************
  pesc_state_s state_reg; // Registered state
  pesc_state_s state_next; // Next state
  pesc_word_t level_bits; // Live read-only indications
  pesc_word_t flag_view; // Flags as software sees them
  pesc_word_t cfg_view; // Configuration as software sees it
  logic rd_flags; // Read of the flag register
  logic wr_cfg; // Write of the configuration register
  logic wr_tally; // Write of the error counter

  // ****************************************
  // Register views and decode
  // ****************************************

  // Read-only level bits are not stored: they track the source
  always_comb
  begin
    level_bits = '0;
    level_bits[`PESC_EV_EEE_ERROR] = eee_error_level; // RULE_05
    level_bits[`PESC_EV_WAKE_PACKET] = wake_packet_level; // RULE_06
    level_bits[`PESC_EV_MAC_BUFFER] = mac_buffer_fault_level; // RULE_07
  end

  // Merge latched and level bits into one read word
  assign flag_view = (state_reg.flags & `PESC_LATCH_MASK) | level_bits;

  // Pack configuration back into its word; reserved bits read zero
  always_comb
  begin
    cfg_view = '0;
    cfg_view[`PESC_CFG_PROBE_START] = state_reg.probe_start;
    cfg_view[`PESC_CFG_INT_POLARITY] = state_reg.int_active_low;
    cfg_view[`PESC_CFG_RETRY_HI:`PESC_CFG_RETRY_LO] = state_reg.retry_count;
    cfg_view[`PESC_CFG_DS_EN] = state_reg.ds_enable;
    cfg_view[`PESC_CFG_DS_ENH] = state_reg.ds_enhanced;
    cfg_view[`PESC_CFG_DS_TEN] = state_reg.ds_to_ten;
    cfg_view[`PESC_CFG_TXCLK_HI:`PESC_CFG_TXCLK_LO] = state_reg.tx_clk_sel;
    cfg_view[`PESC_CFG_FD_COL] = state_reg.fd_collision;
    cfg_view[`PESC_CFG_LEGACY_SCR] = state_reg.legacy_scr;
    cfg_view[`PESC_CFG_SEMI_MASTER] = state_reg.semi_master;
    cfg_view[`PESC_CFG_SEMI_SLAVE] = state_reg.semi_slave;
  end

  // Address decode of the strobes
  assign rd_flags = reg_rd && (reg_addr == `PESC_OFS_EVENT_FLAGS);
  assign wr_cfg = reg_wr && (reg_addr == `PESC_OFS_GEN_CFG_TWO);
  assign wr_tally = reg_wr && (reg_addr == `PESC_OFS_RX_ERR_TALLY);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    state_next = state_reg;

    // Read data: shown the cycle after the strobe, zero otherwise
    state_next.rd_data = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `PESC_OFS_EVENT_FLAGS: state_next.rd_data = flag_view;
        `PESC_OFS_GEN_CFG_TWO: state_next.rd_data = cfg_view;
        `PESC_OFS_RX_ERR_TALLY: state_next.rd_data = state_reg.tally;
        // Unmapped offsets read as zero
        default: state_next.rd_data = '0;
      endcase
    end

    // Flags: a read clears what it returned, new events OR in after,
    // so an event in the read cycle is kept for the next read
    if (rd_flags)
    begin
      state_next.flags = '0; // RULE_03 RULE_04 RULE_08
    end
    // Capture ignores the enable mask entirely
    state_next.flags = state_next.flags | (event_pulse & `PESC_LATCH_MASK); // RULE_01 RULE_02 RULE_21

    // Configuration write
    if (wr_cfg)
    begin
      state_next.int_active_low = reg_wdata[`PESC_CFG_INT_POLARITY]; // RULE_10
      state_next.retry_count = reg_wdata[`PESC_CFG_RETRY_HI:`PESC_CFG_RETRY_LO]; // RULE_11
      state_next.ds_enable = reg_wdata[`PESC_CFG_DS_EN]; // RULE_12
      state_next.ds_enhanced = reg_wdata[`PESC_CFG_DS_ENH]; // RULE_13
      state_next.ds_to_ten = reg_wdata[`PESC_CFG_DS_TEN]; // RULE_14
      state_next.tx_clk_sel = reg_wdata[`PESC_CFG_TXCLK_HI:`PESC_CFG_TXCLK_LO]; // RULE_15
      state_next.fd_collision = reg_wdata[`PESC_CFG_FD_COL]; // RULE_16
      state_next.legacy_scr = reg_wdata[`PESC_CFG_LEGACY_SCR]; // RULE_17
      state_next.semi_master = reg_wdata[`PESC_CFG_SEMI_MASTER]; // RULE_18
      state_next.semi_slave = reg_wdata[`PESC_CFG_SEMI_SLAVE]; // RULE_18
    end

    // Probe start: hardware clear first, so a software set wins
    if (probe_done)
    begin
      state_next.probe_start = 1'b0; // RULE_09
    end
    if (wr_cfg && reg_wdata[`PESC_CFG_PROBE_START])
    begin
      state_next.probe_start = 1'b1; // RULE_09
    end

    // Decoded attempt limit: 1 << code gives 1, 2, 4, 8
    state_next.retry_limit = 4'h1 << state_next.retry_count; // RULE_11
    // Codes 2 and 3 stop the transmit clock
    state_next.tx_clk_on = ~state_next.tx_clk_sel[1]; // RULE_15

    // Error counter: clear ones first, then count; saturates so a
    // flood of errors never wraps back to a small value
    if (wr_tally)
    begin
      state_next.tally = state_reg.tally & ~reg_wdata; // RULE_19
    end
    if (rx_error && (state_next.tally != `PESC_TALLY_MAX))
    begin
      state_next.tally = state_next.tally + 16'h0001; // RULE_19
    end

    // Interrupt pin from the next flags, so it asserts with the event
    state_next.irq_pin = |((state_next.flags | level_bits) & event_enable_mask); // RULE_20
    if (state_next.int_active_low)
    begin
      state_next.irq_pin = ~state_next.irq_pin; // RULE_10
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg.flags <= `PESC_RST_EVENT_FLAGS;
      // Each configuration field is cut from the reset word on purpose by a size cast; retry_limit and tx_clk_on load constants
      state_reg.probe_start <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_PROBE_START);
      state_reg.int_active_low <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_INT_POLARITY);
      state_reg.retry_count <= 2'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_RETRY_LO);
      state_reg.retry_limit <= 4'h4;
      state_reg.ds_enable <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_DS_EN);
      state_reg.ds_enhanced <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_DS_ENH);
      state_reg.ds_to_ten <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_DS_TEN);
      state_reg.tx_clk_sel <= 2'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_TXCLK_LO);
      state_reg.tx_clk_on <= 1'b1;
      state_reg.fd_collision <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_FD_COL);
      state_reg.legacy_scr <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_LEGACY_SCR);
      state_reg.semi_master <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_SEMI_MASTER);
      state_reg.semi_slave <= 1'(`PESC_RST_GEN_CFG_TWO >> `PESC_CFG_SEMI_SLAVE);
      state_reg.tally <= `PESC_RST_RX_ERR_TALLY;
      state_reg.rd_data <= 16'h0000;
      // Polarity resets active low, so an idle pin sits high
      state_reg.irq_pin <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs, each straight from the state register
  // ****************************************
  assign reg_rdata = state_reg.rd_data;
  assign event_irq_pin = state_reg.irq_pin;
  assign powered_device_probe_start = state_reg.probe_start;
  assign downshift_retry_count = state_reg.retry_count;
  assign downshift_retry_limit = state_reg.retry_limit;
  assign downshift_enable = state_reg.ds_enable;
  assign downshift_enhanced_enable = state_reg.ds_enhanced;
  assign downshift_to_ten_enable = state_reg.ds_to_ten;
  assign tx_clk_select = state_reg.tx_clk_sel;
  assign tx_clk_running = state_reg.tx_clk_on;
  assign full_duplex_collision_enable = state_reg.fd_collision;
  assign legacy_scrambler_auto_enable = state_reg.legacy_scr;
  assign semi_cross_master_enable = state_reg.semi_master;
  assign semi_cross_slave_enable = state_reg.semi_slave;
  assign rx_error_tally = state_reg.tally;

endmodule

// *** shared/pesc_consts.svh ***
`ifndef PESC_CONSTS_SVH
`define PESC_CONSTS_SVH

// ****************************************
// Register offsets on the management port
// ****************************************
`define PESC_ADDR_W 5
`define PESC_OFS_EVENT_FLAGS 5'h13
`define PESC_OFS_GEN_CFG_TWO 5'h14
`define PESC_OFS_RX_ERR_TALLY 5'h15

// ****************************************
// Event flag bit positions
// ****************************************
`define PESC_EV_NEG_ERROR 15
`define PESC_EV_SPEED_CHANGE 14
`define PESC_EV_DUPLEX_CHANGE 13
`define PESC_EV_PAGE_RX 12
`define PESC_EV_NEG_DONE 11
`define PESC_EV_LINK_CHANGE 10
`define PESC_EV_EEE_ERROR 9
`define PESC_EV_BOGUS_CARRIER 8
`define PESC_EV_CONV_FIFO 7
`define PESC_EV_CROSSOVER 6
`define PESC_EV_DOWNSHIFT 5
`define PESC_EV_SLEEP_CHANGE 4
`define PESC_EV_WAKE_PACKET 3
`define PESC_EV_MAC_BUFFER 2
`define PESC_EV_POLARITY 1
`define PESC_EV_JABBER 0
// Bits that latch high and clear on read (15..10, 8..4, 1, 0)
`define PESC_LATCH_MASK 16'hfdf3

// ****************************************
// Configuration field positions
// ****************************************
`define PESC_CFG_PROBE_START 15
`define PESC_CFG_INT_POLARITY 13
`define PESC_CFG_RETRY_HI 11
`define PESC_CFG_RETRY_LO 10
`define PESC_CFG_DS_EN 9
`define PESC_CFG_DS_ENH 8
`define PESC_CFG_DS_TEN 6
`define PESC_CFG_TXCLK_HI 5
`define PESC_CFG_TXCLK_LO 4
`define PESC_CFG_FD_COL 3
`define PESC_CFG_LEGACY_SCR 2
`define PESC_CFG_SEMI_MASTER 1
`define PESC_CFG_SEMI_SLAVE 0

// ****************************************
// Reset values
// ****************************************
`define PESC_RST_EVENT_FLAGS 16'h0000
`define PESC_RST_GEN_CFG_TWO 16'h2947
`define PESC_RST_RX_ERR_TALLY 16'h0000
`define PESC_TALLY_MAX 16'hffff

`endif

// *** shared/pesc_pkg.sv ***
// ****************************************
// Types shared by the register group
// ****************************************
package pesc_pkg;

  typedef logic [15:0] pesc_word_t;

  // Whole state of the register group
  typedef struct packed {
    pesc_word_t flags; // Latched event flags
    logic probe_start; // Powered-device probe request
    logic int_active_low; // Interrupt pin polarity
    logic [1:0] retry_count; // Failed attempts code
    logic [3:0] retry_limit; // Decoded attempt count
    logic ds_enable; // Downshift enable
    logic ds_enhanced; // Enhanced downshift enable
    logic ds_to_ten; // Fallback to 10M enable
    logic [1:0] tx_clk_sel; // Transmit clock selection
    logic tx_clk_on; // Transmit clock running
    logic fd_collision; // Collision indication in full duplex
    logic legacy_scr; // Legacy scrambler auto select
    logic semi_master; // Semi-cross in master role
    logic semi_slave; // Semi-cross in slave role
    pesc_word_t tally; // Receive error counter
    pesc_word_t rd_data; // Read data register
    logic irq_pin; // Interrupt pin level
  } pesc_state_s;

endpackage

// *** testbench/pesc_regs_checker.sv ***
`timescale 1ns/1ps
`include "pesc_consts.svh"
module pesc_regs_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] event_pulse,
  input wire logic eee_error_level,
  input wire logic [15:0] event_enable_mask,
  input wire logic rx_error,
  input wire logic event_irq_pin,
  input wire logic powered_device_probe_start,
  input wire logic [1:0] downshift_retry_count,
  input wire logic [3:0] downshift_retry_limit,
  input wire logic downshift_enable,
  input wire logic [1:0] tx_clk_select,
  input wire logic tx_clk_running,
  input wire logic [15:0] rx_error_tally
);
  // ****************
  // Decoded strobes
  // ****************
  logic rd_ev;
  logic wr_cfg;
  logic wr_tal;
  // Copy of the polarity bit, so the pin can be judged from the ports alone
  logic pol_reg;
  assign rd_ev = reg_rd && reg_addr == `PESC_OFS_EVENT_FLAGS;
  assign wr_cfg = reg_wr && reg_addr == `PESC_OFS_GEN_CFG_TWO;
  assign wr_tal = reg_wr && reg_addr == `PESC_OFS_RX_ERR_TALLY;
  // Track software writes of the polarity bit
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      pol_reg <= 1'b1;
    else if (wr_cfg)
      pol_reg <= reg_wdata[`PESC_CFG_INT_POLARITY];
  // ****************
  // Properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_ev_seen;
    (|(event_pulse & `PESC_LATCH_MASK)) ##1 rd_ev |=> (reg_rdata & $past(event_pulse, 2)
      & `PESC_LATCH_MASK) == ($past(event_pulse, 2) & `PESC_LATCH_MASK);
  endproperty
  a_ev_seen: assert property (p_ev_seen) else $error("event flag missing on read");
  property p_lvl;
    rd_ev |=> reg_rdata[9] == $past(eee_error_level);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level flag wrong on read");
  property p_irq;
    (|(event_pulse & event_enable_mask & `PESC_LATCH_MASK)) && !wr_cfg
      |=> event_irq_pin == !pol_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("pin not asserted on event");
  property p_cfg;
    wr_cfg |=> downshift_enable == $past(reg_wdata[9]) && tx_clk_select == $past(reg_wdata[5:4])
      && downshift_retry_count == $past(reg_wdata[11:10]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config fields wrong");
  property p_probe;
    wr_cfg && reg_wdata[15] |=> powered_device_probe_start;
  endproperty
  a_probe: assert property (p_probe) else $error("probe start not set");
  property p_lim;
    downshift_retry_limit == (4'h1 << downshift_retry_count);
  endproperty
  a_lim: assert property (p_lim) else $error("retry limit decode wrong");
  property p_run;
    tx_clk_running == !tx_clk_select[1];
  endproperty
  a_run: assert property (p_run) else $error("transmit clock enable wrong");
  property p_inc;
    rx_error && !wr_tal && rx_error_tally != 16'hffff
      |=> rx_error_tally == $past(rx_error_tally) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("tally did not count");
  property p_clr;
    wr_tal && !rx_error |=> rx_error_tally == ($past(rx_error_tally) & ~$past(reg_wdata));
  endproperty
  a_clr: assert property (p_clr) else $error("tally clear wrong");
  c_irq: cover property (event_irq_pin != pol_reg);
  c_rd: cover property (rd_ev ##1 reg_rdata != 16'h0000);
  c_clr: cover property (wr_tal ##1 rx_error_tally == 16'h0000);
endmodule
bind pesc_regs pesc_regs_checker u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .event_pulse, .eee_error_level, .event_enable_mask, .rx_error,
  .event_irq_pin, .powered_device_probe_start, .downshift_retry_count, .downshift_retry_limit,
  .downshift_enable, .tx_clk_select, .tx_clk_running, .rx_error_tally);

// *** testbench/pesc_regs_tb.sv ***
`timescale 1ns/1ps
`include "pesc_consts.svh"
module pesc_regs_tb;
  import pesc_pkg::*;
  // ****************
  // Stimulus and observed ports
  // ****************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] ev = 16'h0000;
  logic [15:0] mask = 16'h0000;
  logic [2:0] lvl = 3'h0;
  logic done = 1'b0;
  logic rx_err = 1'b0;
  logic [15:0] rdata;
  logic pin;
  logic probe;
  logic [3:0] lim;
  logic run;
  logic [15:0] tally;
  int num_errors = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  pesc_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .event_pulse(ev), .eee_error_level(lvl[2]), .wake_packet_level(lvl[1]),
    .mac_buffer_fault_level(lvl[0]), .event_enable_mask(mask), .probe_done(done),
    .rx_error(rx_err), .event_irq_pin(pin), .powered_device_probe_start(probe),
    .downshift_retry_count(), .downshift_retry_limit(lim), .downshift_enable(),
    .downshift_enhanced_enable(), .downshift_to_ten_enable(), .tx_clk_select(),
    .tx_clk_running(run), .full_duplex_collision_enable(), .legacy_scrambler_auto_enable(),
    .semi_cross_master_enable(), .semi_cross_slave_enable(), .rx_error_tally(tally));
  // ****************
  // Bus and compare helpers
  // ****************
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe, so it is judged there
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task pulse(input logic [15:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 16'h0000;
    #1;
  endtask
  task test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    chk("pin", 16'h0001, {15'h0, pin});
    rd(`PESC_OFS_EVENT_FLAGS, 16'h0000);
    rd(`PESC_OFS_GEN_CFG_TWO, 16'h2947);
    rd(`PESC_OFS_RX_ERR_TALLY, 16'h0000);
    rd(5'h00, 16'h0000);
  endtask
  task t_cfg;
    wr(`PESC_OFS_GEN_CFG_TWO, 16'hffff);
    rd(`PESC_OFS_GEN_CFG_TWO, 16'haf7f);
    done <= 1'b1;
    wr(`PESC_OFS_GEN_CFG_TWO, 16'h2000);
    done <= 1'b0;
    #1 chk("probe", 16'h0000, {15'h0, probe});
    for (int k = 0; k < 4; k++)
    begin
      wr(`PESC_OFS_GEN_CFG_TWO, 16'h2000 | 16'(k << 10) | 16'(k << 4));
      #1 chk("limit", 16'(1 << k), {12'h0, lim});
      chk("txrun", 16'(k < 2), {15'h0, run});
    end
  endtask
  task t_events;
    lvl <= 3'h7;
    pulse(`PESC_LATCH_MASK);
    chk("pin", 16'h0001, {15'h0, pin});
    rd(`PESC_OFS_EVENT_FLAGS, 16'hffff);
    rd(`PESC_OFS_EVENT_FLAGS, 16'h020c);
    lvl <= 3'h0;
    rd(`PESC_OFS_EVENT_FLAGS, 16'h0000);
  endtask
  task t_irq;
    mask <= 16'h4002;
    pulse(16'h4000);
    chk("pin", 16'h0000, {15'h0, pin});
    rd(`PESC_OFS_EVENT_FLAGS, 16'h4000);
    #1 chk("pin", 16'h0001, {15'h0, pin});
    wr(`PESC_OFS_GEN_CFG_TWO, 16'h0947);
    pulse(16'h0002);
    chk("pin", 16'h0001, {15'h0, pin});
    rd(`PESC_OFS_EVENT_FLAGS, 16'h0002);
  endtask
  task t_race;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= `PESC_OFS_EVENT_FLAGS;
    ev <= 16'h0400;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    ev <= 16'h0000;
    rd(`PESC_OFS_EVENT_FLAGS, 16'h0400);
    // Event followed at once by a read: the read must already see it
    @(posedge sys_clk);
    ev <= 16'h0800;
    @(posedge sys_clk);
    ev <= 16'h0000;
    reg_rd <= 1'b1;
    reg_addr <= `PESC_OFS_EVENT_FLAGS;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", 16'h0800, rdata);
  endtask
  task t_tally;
    @(posedge sys_clk);
    rx_err <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rx_err <= 1'b0;
    rd(`PESC_OFS_RX_ERR_TALLY, 16'h0005);
    wr(`PESC_OFS_RX_ERR_TALLY, 16'h0001);
    #1 chk("tally", 16'h0004, tally);
    wr(`PESC_OFS_RX_ERR_TALLY, 16'hffff);
    rd(`PESC_OFS_RX_ERR_TALLY, 16'h0000);
  endtask
  // ****************
  // Main sequence and watchdog
  // ****************
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_cfg();
    t_events();
    t_irq();
    t_race();
    t_tally();
    test_done();
  end
  // Whole run takes under a hundred cycles; this limit only catches a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
